/* File: src/pmr_bank.sv */
// Performance monitor register bank: control, enables, overflow, counters, identification.
// Assumes requests arrive from the core's system-register move unit on the core clock.
`timescale 1ns/10ps
`default_nettype none
`include "pmr_defines.svh"

module pmr_bank #(
    parameter logic [15:0] CTRL_ID_CODE = `PMR_CTRL_ID_DEFAULT
) (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire pmr_pkg::pmr_req_t      req,
    input  wire logic [63:0]            event_in,
    output var pmr_pkg::pmr_resp_t      resp,
    output logic [31:0]                 overflow_status
);
    import pmr_pkg::*;

    localparam int NC = `PMR_NUM_COUNTERS;

    // Identification value; the arbitrary code above only fills the implementer field.
    logic [63:0] ident_low;
    logic [63:0] ident_high;
    assign ident_low  = `PMR_IDENT_LOW_VALUE;
    assign ident_high = `PMR_IDENT_HIGH_VALUE;

    // Control and configuration state.
    logic        ctl_enable;
    logic        ctl_divider;
    logic        ctl_export;
    logic        ctl_disprohib;
    logic        ctl_longcyc;
    logic [31:0] cnt_enable;
    logic [31:0] ovf_flags;
    logic [31:0] irq_enable;
    logic [4:0]  select;
    logic [31:0] user_enable;
    logic [31:0] cycle_filter;
    logic [31:0] ev_type [NC];

    logic        next_ctl_enable;
    logic        next_ctl_divider;
    logic        next_ctl_export;
    logic        next_ctl_disprohib;
    logic        next_ctl_longcyc;
    logic [31:0] next_cnt_enable;
    logic [31:0] next_ovf_flags;
    logic [31:0] next_irq_enable;
    logic [4:0]  next_select;
    logic [31:0] next_user_enable;
    logic [31:0] next_cycle_filter;
    logic [31:0] next_ev_type [NC];

    logic        wr_ctrl;
    logic        ev_reset_req;
    logic        cyc_reset_req;
    logic [31:0] hw_ovf;
    logic [31:0] ev_count [NC];
    logic [NC-1:0] ev_wrap;
    logic [NC-1:0] ev_inc;
    logic [NC-1:0] ev_load;

    // The system-register request port changes the configuration state; counter wraps also set overflow flags.
    assign wr_ctrl       = req.wr && (req.id == `PMR_ID_CONTROL);
    assign ev_reset_req  = wr_ctrl && req.wdata[`PMR_CTRL_EVRESET];
    assign cyc_reset_req = wr_ctrl && req.wdata[`PMR_CTRL_CYCRESET];

    always_comb begin
        next_ctl_enable    = ctl_enable;
        next_ctl_divider   = ctl_divider;
        next_ctl_export    = ctl_export;
        next_ctl_disprohib = ctl_disprohib;
        next_ctl_longcyc   = ctl_longcyc;
        next_cnt_enable    = cnt_enable;
        next_irq_enable    = irq_enable;
        next_select        = select;
        next_user_enable   = user_enable;
        next_cycle_filter  = cycle_filter;
        next_ovf_flags     = ovf_flags;
        for (int i = 0; i < NC; i++) begin
            next_ev_type[i] = ev_type[i];
        end
        if (req.wr) begin
            if (req.id == `PMR_ID_CONTROL) begin
                next_ctl_enable    = req.wdata[`PMR_CTRL_ENABLE];
                next_ctl_divider   = req.wdata[`PMR_CTRL_DIVIDER];
                next_ctl_export    = req.wdata[`PMR_CTRL_EXPORT];
                next_ctl_disprohib = req.wdata[`PMR_CTRL_DISPROHIB];
                next_ctl_longcyc   = req.wdata[`PMR_CTRL_LONGCYC];
            end else if (req.id == `PMR_ID_CNTEN_SET) begin
                next_cnt_enable = cnt_enable | (req.wdata[31:0] & `PMR_IMPL_MASK);
            end else if (req.id == `PMR_ID_CNTEN_CLR) begin
                next_cnt_enable = cnt_enable & ~req.wdata[31:0];
            end else if (req.id == `PMR_ID_OVF_CLR) begin
                next_ovf_flags = ovf_flags & ~req.wdata[31:0];
            end else if (req.id == `PMR_ID_OVF_SET) begin
                next_ovf_flags = ovf_flags | (req.wdata[31:0] & `PMR_IMPL_MASK);
            end else if (req.id == `PMR_ID_IRQ_EN_SET) begin
                next_irq_enable = irq_enable | (req.wdata[31:0] & `PMR_IMPL_MASK);
            end else if (req.id == `PMR_ID_IRQ_EN_CLR) begin
                next_irq_enable = irq_enable & ~req.wdata[31:0];
            end else if (req.id == `PMR_ID_SELECT) begin
                next_select = req.wdata[4:0];
            end else if (req.id == `PMR_ID_USER_ENABLE) begin
                next_user_enable = req.wdata[31:0];
            end else if (req.id == `PMR_ID_CYCLE_FILTER) begin
                next_cycle_filter = req.wdata[31:0];
            end else if (req.id == `PMR_ID_SEL_TYPE) begin
                if (select == `PMR_SEL_CYCLE) begin
                    next_cycle_filter = req.wdata[31:0];
                end else if (select < 5'(NC)) begin
                    next_ev_type[select[2:0]] = req.wdata[31:0];
                end
            end else if ((req.id >= `PMR_ID_EVTYPE_BASE) && (req.id < `PMR_ID_EVTYPE_BASE + 6'(NC))) begin
                next_ev_type[3'(req.id - `PMR_ID_EVTYPE_BASE)] = req.wdata[31:0];
            end
        end
        // A wrap in the same cycle as a clear write still leaves its flag set.
        next_ovf_flags = next_ovf_flags | hw_ovf;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctl_enable    <= 1'b0;
            ctl_divider   <= 1'b0;
            ctl_export    <= 1'b0;
            ctl_disprohib <= 1'b0;
            ctl_longcyc   <= 1'b0;
            cnt_enable    <= 32'h00000000;
            ovf_flags     <= 32'h00000000;
            irq_enable    <= 32'h00000000;
            select        <= 5'h00;
            user_enable   <= 32'h00000000;
            cycle_filter  <= 32'h00000000;
            for (int i = 0; i < NC; i++) begin
                ev_type[i] <= 32'h00000000;
            end
        end else begin
            ctl_enable    <= next_ctl_enable;
            ctl_divider   <= next_ctl_divider;
            ctl_export    <= next_ctl_export;
            ctl_disprohib <= next_ctl_disprohib;
            ctl_longcyc   <= next_ctl_longcyc;
            cnt_enable    <= next_cnt_enable;
            ovf_flags     <= next_ovf_flags;
            irq_enable    <= next_irq_enable;
            select        <= next_select;
            user_enable   <= next_user_enable;
            cycle_filter  <= next_cycle_filter;
            for (int i = 0; i < NC; i++) begin
                ev_type[i] <= next_ev_type[i];
            end
        end
    end

    // Event counters.
    genvar g;
    generate
        for (g = 0; g < NC; g++) begin : gen_cnt
            logic [`PMR_EVT_FIELD_W-1:0] evnum;
            logic                        src;
            assign evnum = ev_type[g][`PMR_EVT_FIELD_W-1:0];
            if (g % 2 == 1) begin : gen_odd
                assign src = (evnum == `PMR_EVT_CHAIN) ? ev_wrap[g-1] :
                             (evnum == `PMR_EVT_SW_INC) ?
                             (req.wr && req.id == `PMR_ID_SW_INC && req.wdata[g]) :
                             ((evnum < 10'h040) && event_in[6'(evnum)]);
            end else begin : gen_even
                assign src = (evnum == `PMR_EVT_CHAIN) ? 1'b0 :
                             (evnum == `PMR_EVT_SW_INC) ?
                             (req.wr && req.id == `PMR_ID_SW_INC && req.wdata[g]) :
                             ((evnum < 10'h040) && event_in[6'(evnum)]);
            end
            assign ev_inc[g]  = ctl_enable && cnt_enable[g] && src;
            assign ev_load[g] = req.wr && ((req.id == `PMR_ID_EVCOUNT_BASE + 6'(g)) ||
                                ((req.id == `PMR_ID_SEL_COUNT) && (select == 5'(g))));
            pmr_counter u_cnt (
                .mclk     (mclk),
                .rst      (rst),
                .load     (ev_load[g]),
                .load_val (req.wdata[31:0]),
                .clear    (ev_reset_req),
                .inc      (ev_inc[g]),
                .count    (ev_count[g]),
                .wrap     (ev_wrap[g])
            );
        end
    endgenerate

    // Cycle counter with optional divide-by-64 prescaler.
    logic [63:0] cycle_count;
    logic [63:0] next_cycle_count;
    logic [5:0]  prescale;
    logic [5:0]  next_prescale;
    logic        cyc_tick;
    logic        cyc_wrap;

    always_comb begin
        next_prescale    = prescale;
        next_cycle_count = cycle_count;
        cyc_tick         = 1'b0;
        cyc_wrap         = 1'b0;
        if (ctl_enable && cnt_enable[`PMR_CYCLE_BIT]) begin
            next_prescale = prescale + 6'h01;
            cyc_tick      = !ctl_divider || (prescale == `PMR_DIV_COUNT);
        end
        if (req.wr && req.id == `PMR_ID_CYCLE_COUNT) begin
            next_cycle_count = req.wdata;
        end else if (cyc_reset_req) begin
            next_cycle_count = 64'h0000000000000000;
            next_prescale    = 6'h00;
        end else if (cyc_tick) begin
            next_cycle_count = cycle_count + 64'h0000000000000001;
            cyc_wrap = ctl_longcyc ? (cycle_count == 64'hFFFFFFFFFFFFFFFF)
                                   : (cycle_count[31:0] == 32'hFFFFFFFF);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cycle_count <= 64'h0000000000000000;
            prescale    <= 6'h00;
        end else begin
            cycle_count <= next_cycle_count;
            prescale    <= next_prescale;
        end
    end

    // The cycle reset leaves its overflow flag alone; a real wrap or a PMR_ID_OVF_SET write sets it.
    assign hw_ovf = {cyc_wrap, 25'h0000000, ev_wrap};

    // Read path; answers are registered one cycle after the request.
    logic [63:0] rd_value;
    logic [31:0] ctrl_read;
    pmr_resp_t   next_resp;

    assign ctrl_read = {CTRL_ID_CODE, `PMR_CTRL_NUM_CNT, 4'h0, ctl_longcyc, ctl_disprohib,
                        ctl_export, ctl_divider, 1'b0, 1'b0, ctl_enable};

    always_comb begin
        rd_value = 64'h0000000000000000;
        if (req.id == `PMR_ID_CONTROL) begin
            rd_value = {32'h00000000, ctrl_read};
        end else if (req.id == `PMR_ID_CNTEN_SET || req.id == `PMR_ID_CNTEN_CLR) begin
            rd_value = {32'h00000000, cnt_enable};
        end else if (req.id == `PMR_ID_OVF_CLR || req.id == `PMR_ID_OVF_SET) begin
            rd_value = {32'h00000000, ovf_flags};
        end else if (req.id == `PMR_ID_IRQ_EN_SET || req.id == `PMR_ID_IRQ_EN_CLR) begin
            rd_value = {32'h00000000, irq_enable};
        end else if (req.id == `PMR_ID_SELECT) begin
            rd_value = {59'h0, select};
        end else if (req.id == `PMR_ID_IDENT_LOW) begin
            rd_value = ident_low;
        end else if (req.id == `PMR_ID_IDENT_HIGH) begin
            rd_value = ident_high;
        end else if (req.id == `PMR_ID_CYCLE_COUNT) begin
            rd_value = cycle_count;
        end else if (req.id == `PMR_ID_USER_ENABLE) begin
            rd_value = {32'h00000000, user_enable};
        end else if (req.id == `PMR_ID_CYCLE_FILTER) begin
            rd_value = {32'h00000000, cycle_filter};
        end else if (req.id == `PMR_ID_SEL_TYPE) begin
            if (select == `PMR_SEL_CYCLE) begin
                rd_value = {32'h00000000, cycle_filter};
            end else if (select < 5'(NC)) begin
                rd_value = {32'h00000000, ev_type[select[2:0]]};
            end
        end else if (req.id == `PMR_ID_SEL_COUNT) begin
            if (select < 5'(NC)) begin
                rd_value = {32'h00000000, ev_count[select[2:0]]};
            end
        end else if ((req.id >= `PMR_ID_EVCOUNT_BASE) && (req.id < `PMR_ID_EVCOUNT_BASE + 6'(NC))) begin
            rd_value = {32'h00000000, ev_count[3'(req.id - `PMR_ID_EVCOUNT_BASE)]};
        end else if ((req.id >= `PMR_ID_EVTYPE_BASE) && (req.id < `PMR_ID_EVTYPE_BASE + 6'(NC))) begin
            rd_value = {32'h00000000, ev_type[3'(req.id - `PMR_ID_EVTYPE_BASE)]};
        end
        next_resp.valid = req.rd;
        next_resp.rdata = req.rd ? rd_value : 64'h0000000000000000;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            resp <= '0;
        end else begin
            resp <= next_resp;
        end
    end

    // Overflow flags are visible outside for an interrupt controller to combine.
    assign overflow_status = ovf_flags;
endmodule

`default_nettype wire

/* File: shared/pmr_defines.svh */
// Constants of the performance monitor register bank: register codes, fields, resets.
// Assumes a single core clock and a system-register request port of the core.
`ifndef PMR_DEFINES_SVH
`define PMR_DEFINES_SVH

// System-register codes carried on the request port.
`define PMR_ID_CONTROL        6'h00
`define PMR_ID_CNTEN_SET      6'h01
`define PMR_ID_CNTEN_CLR      6'h02
`define PMR_ID_OVF_CLR        6'h03
`define PMR_ID_SW_INC         6'h04
`define PMR_ID_SELECT         6'h05
`define PMR_ID_IDENT_LOW      6'h06
`define PMR_ID_IDENT_HIGH     6'h07
`define PMR_ID_CYCLE_COUNT    6'h08
`define PMR_ID_SEL_TYPE       6'h09
`define PMR_ID_CYCLE_FILTER   6'h0A
`define PMR_ID_SEL_COUNT      6'h0B
`define PMR_ID_USER_ENABLE    6'h0C
`define PMR_ID_IRQ_EN_SET     6'h0D
`define PMR_ID_IRQ_EN_CLR     6'h0E
`define PMR_ID_OVF_SET        6'h0F
`define PMR_ID_EVCOUNT_BASE   6'h10
`define PMR_ID_EVTYPE_BASE    6'h18

// Control register fields.
`define PMR_CTRL_ENABLE       0
`define PMR_CTRL_EVRESET      1
`define PMR_CTRL_CYCRESET     2
`define PMR_CTRL_DIVIDER      3
`define PMR_CTRL_EXPORT       4
`define PMR_CTRL_DISPROHIB    5
`define PMR_CTRL_LONGCYC      6
`define PMR_CTRL_NUM_CNT      5'h06
// Arbitrary identification code of our own; it names no maker and no part.
`define PMR_CTRL_ID_DEFAULT   16'h0000

// Counter layout and events.
`define PMR_NUM_COUNTERS      6
`define PMR_CYCLE_BIT         31
`define PMR_IMPL_MASK         32'h8000003F
`define PMR_EVT_FIELD_W       10
`define PMR_EVT_SW_INC        10'h000
`define PMR_EVT_CHAIN         10'h01E
`define PMR_SEL_CYCLE         5'h1F
`define PMR_DIV_COUNT         6'h3F

// Fixed identification values.
`define PMR_IDENT_LOW_VALUE   64'h00000A7F7FFF0F3F
`define PMR_IDENT_HIGH_VALUE  64'h0000000FEF2AE7F

`endif

/* File: shared/pmr_pkg.sv */
// Types of the performance monitor register bank.
// Assumes pmr_defines.svh sits beside it on the include path.
package pmr_pkg;
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [5:0]  id;
        logic [63:0] wdata;
    } pmr_req_t;

    typedef struct packed {
        logic        valid;
        logic [63:0] rdata;
    } pmr_resp_t;
endpackage

/* File: src/pmr_counter.sv */
// One 32-bit event counter with load, clear and increment.
// Gives load priority over clear and clear over increment.
`timescale 1ns/10ps
`default_nettype none

module pmr_counter (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        load,
    input  wire logic [31:0] load_val,
    input  wire logic        clear,
    input  wire logic        inc,
    output logic [31:0]      count,
    output logic             wrap
);
    logic [31:0] next_count;

    always_comb begin
        next_count = count;
        wrap       = 1'b0;
        if (load) begin
            next_count = load_val;
        end else if (clear) begin
            next_count = 32'h00000000;
        end else if (inc) begin
            next_count = count + 32'h00000001;
            wrap       = (count == 32'hFFFFFFFF);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count <= 32'h00000000;
        end else begin
            count <= next_count;
        end
    end
endmodule

`default_nettype wire

/* File: sim/pmr_bank_checker.sv */
// Port-level checker of the performance monitor register bank.
// Assumes the bank's core clock and asynchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
`include "pmr_defines.svh"

module pmr_bank_checker (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire pmr_pkg::pmr_req_t  req,
    input  wire logic [63:0]        event_in,
    input  wire pmr_pkg::pmr_resp_t resp,
    input  wire logic [31:0]        overflow_status
);
    import pmr_pkg::*;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_ident_rd;
        req.rd && req.id == `PMR_ID_IDENT_LOW;
    endsequence

    sequence s_ctrl_rd;
        req.rd && req.id == `PMR_ID_CONTROL;
    endsequence

    a_read_gets_answer: assert property (req.rd |=> resp.valid) else $error("read got no answer");
    a_answer_needs_read: assert property (resp.valid |-> $past(req.rd)) else $error("answer without read");
    a_ident_full_value: assert property (
        s_ident_rd |=> resp.rdata == `PMR_IDENT_LOW_VALUE) else $error("ident value");
    a_ident_upper_zero: assert property (
        s_ident_rd |=> resp.rdata[63:44] == 20'h00000) else $error("ident upper");
    a_ident_miss_flags: assert property (
        s_ident_rd |=> resp.rdata[43:39] == 5'h14) else $error("ident 43-39");
    a_ident_sample_flags: assert property (
        s_ident_rd |=> resp.rdata[38:32] == 7'h7F) else $error("ident 38-32");
    a_ident_chain_flags: assert property (
        s_ident_rd |=> resp.rdata[31:22] == 10'h1FF) else $error("ident 31-22");
    a_ctrl_counter_num: assert property (
        s_ctrl_rd |=> resp.rdata[15:11] == `PMR_CTRL_NUM_CNT) else $error("count field");
    a_ctrl_reset_raz: assert property (
        s_ctrl_rd |=> resp.rdata[2:1] == 2'h0) else $error("reset bits read");
    a_unimpl_flags_zero: assert property (
        overflow_status[30:6] == 25'h0000000) else $error("unimplemented flag set");
    a_cyc_reset_keeps: assert property (
        (req.wr && req.id == `PMR_ID_CONTROL && req.wdata[2] && overflow_status[31])
        |=> overflow_status[31]) else $error("cycle reset cleared flag");
    a_flag_fall_cause: assert property (
        |($past(overflow_status) & ~overflow_status)
        |-> $past(req.wr && req.id == `PMR_ID_OVF_CLR)) else $error("flag fell without clear");

    c_ident_read: cover property (s_ident_rd);
    c_cycle_reset: cover property (req.wr && req.id == `PMR_ID_CONTROL && req.wdata[2]);
    c_cycle_wrap: cover property ($rose(overflow_status[31]));
    c_even_wrap: cover property ($rose(overflow_status[0]));
endmodule

bind pmr_bank pmr_bank_checker chk_u (
    .mclk(mclk),
    .rst(rst),
    .req(req),
    .event_in(event_in),
    .resp(resp),
    .overflow_status(overflow_status)
);
`default_nettype wire

/* File: sim/pmr_bank_bench.sv */
// Self-checking bench of the performance monitor register bank.
// Assumes the design sources, the package and pmr_defines.svh are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
`include "pmr_defines.svh"

module pmr_bank_bench;
    import pmr_pkg::*;

    logic        mclk;
    logic        rst;
    pmr_req_t    req;
    logic [63:0] event_in;
    pmr_resp_t   resp;
    logic [31:0] overflow_status;
    int          err_count;
    int          tests_run;
    int          cycles;

    pmr_bank #(.CTRL_ID_CODE(16'h0000)) dut_u (
        .mclk(mclk),
        .rst(rst),
        .req(req),
        .event_in(event_in),
        .resp(resp),
        .overflow_status(overflow_status)
    );

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Requests change one time unit after the edge and are held across the taking edge.
    task automatic wr(input logic [5:0] id, input logic [63:0] d);
        @(posedge mclk);
        #1;
        req.wr = 1'b1;
        req.id = id;
        req.wdata = d;
        @(posedge mclk);
        #1;
        req.wr = 1'b0;
    endtask

    task automatic rdchk(input logic [5:0] id, input logic [63:0] exp);
        int n;
        n = 0;
        @(posedge mclk);
        #1;
        req.rd = 1'b1;
        req.id = id;
        @(posedge mclk);
        #1;
        req.rd = 1'b0;
        while (resp.valid !== 1'b1 && n < 3) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk({63'h0, resp.valid}, 64'h1);
        chk(resp.rdata, exp);
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        int n;
        rst = 1'b1;
        req = '0;
        event_in = 64'h0;
        err_count = 0;
        tests_run = 0;
        cycles = 0;
        repeat (8) @(posedge mclk);
        #1;
        rst = 1'b0;

        rdchk(`PMR_ID_IDENT_LOW, 64'h00000A7F7FFF0F3F);
        wr(`PMR_ID_IDENT_LOW, 64'hFFFFFFFFFFFFFFFF);
        rdchk(`PMR_ID_IDENT_LOW, 64'h00000A7F7FFF0F3F);
        rdchk(`PMR_ID_IDENT_HIGH, `PMR_IDENT_HIGH_VALUE);
        rdchk(`PMR_ID_CONTROL, {48'h0, 5'h06, 11'h000});

        // Only six event counters and the cycle counter can be enabled.
        wr(`PMR_ID_CNTEN_SET, 64'hFFFFFFFF);
        rdchk(`PMR_ID_CNTEN_SET, 64'h8000003F);
        wr(`PMR_ID_CNTEN_CLR, 64'hFFFFFFFF);
        rdchk(`PMR_ID_CNTEN_SET, 64'h0);
        wr(`PMR_ID_EVCOUNT_BASE + 6'h06, 64'h1);
        rdchk(`PMR_ID_EVCOUNT_BASE + 6'h06, 64'h0);

        // Cycle counter wraps at bit 31, then a cycle reset must leave its flag set.
        wr(`PMR_ID_CYCLE_COUNT, 64'h00000000FFFFFFFC);
        wr(`PMR_ID_CNTEN_SET, 64'h80000000);
        wr(`PMR_ID_CONTROL, 64'h1);
        n = 0;
        while (overflow_status[31] !== 1'b1 && n < 20) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk({63'h0, overflow_status[31]}, 64'h1);
        wr(`PMR_ID_CONTROL, 64'h4);
        rdchk(`PMR_ID_CYCLE_COUNT, 64'h0);
        rdchk(`PMR_ID_CONTROL, {48'h0, 5'h06, 11'h000});
        chk({63'h0, overflow_status[31]}, 64'h1);
        wr(`PMR_ID_OVF_CLR, 64'h80000000);
        chk({63'h0, overflow_status[31]}, 64'h0);

        // Counter 0 wraps on one event; odd counter 1 chains, even counter 2 must not.
        wr(`PMR_ID_EVTYPE_BASE, 64'h5);
        wr(`PMR_ID_EVTYPE_BASE + 6'h01, 64'h01E);
        wr(`PMR_ID_EVTYPE_BASE + 6'h02, 64'h01E);
        wr(`PMR_ID_EVTYPE_BASE + 6'h03, 64'h000);
        wr(`PMR_ID_EVCOUNT_BASE, 64'hFFFFFFFF);
        wr(`PMR_ID_CNTEN_SET, 64'hF);
        wr(`PMR_ID_CONTROL, 64'h1);
        @(posedge mclk);
        #1;
        event_in[5] = 1'b1;
        @(posedge mclk);
        #1;
        event_in[5] = 1'b0;
        wr(`PMR_ID_SW_INC, 64'h8);
        wr(`PMR_ID_CONTROL, 64'h0);
        rdchk(`PMR_ID_EVCOUNT_BASE, 64'h0);
        rdchk(`PMR_ID_EVCOUNT_BASE + 6'h01, 64'h1);
        rdchk(`PMR_ID_EVCOUNT_BASE + 6'h02, 64'h0);
        rdchk(`PMR_ID_EVCOUNT_BASE + 6'h03, 64'h1);
        chk({62'h0, overflow_status[1:0]}, 64'h1);

        // Selected access, event counter reset that keeps flags, and a selector past the six counters.
        wr(`PMR_ID_SELECT, 64'h1);
        rdchk(`PMR_ID_SEL_COUNT, 64'h1);
        wr(`PMR_ID_CONTROL, 64'h2);
        rdchk(`PMR_ID_SEL_COUNT, 64'h0);
        chk({63'h0, overflow_status[0]}, 64'h1);
        wr(`PMR_ID_SELECT, 64'h6);
        wr(`PMR_ID_SEL_COUNT, 64'h5);
        rdchk(`PMR_ID_SEL_COUNT, 64'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
